// >>> rtl/t2brc_timer.v
`timescale 1ns/1ps
`default_nettype none
`include "t2brc_defines.vh"
module t2brc_timer (
  input  wire                       i_clk,
  input  wire                       i_sys_rst,
  input  wire [`T2BRC_ADDR_W-1:0]   i_addr,
  input  wire [7:0]                 i_wdata,
  input  wire                       i_wr,
  input  wire                       i_rd,
  output reg  [7:0]                 o_rdata,
  input  wire                       i_ext_trigger_pin,
  input  wire                       i_ext_count_input,
  input  wire                       i_timer1_ovf,
  output reg                        o_tx_baud_tick,
  output reg                        o_rx_baud_tick,
  output reg                        o_irq_req
);
  reg  [7:0]               ctrl_ff;
  reg  [15:0]              count_ff;
  reg  [15:0]              reload_ff;
  reg                      six_clk_ff;
  reg  [`T2BRC_PRE_W-1:0]  pre_ff;
  reg  [7:0]               nxt_ctrl;
  reg  [15:0]              nxt_count;
  reg  [15:0]              nxt_reload;
  reg  [`T2BRC_PRE_W-1:0]  nxt_pre;
  reg  [`T2BRC_PRE_W-1:0]  pre_top;
  reg                      tick;
  reg                      roll;
  reg                      ovf_set;
  reg                      extf_set;
  wire                     trig_fall;
  wire                     cnt_fall;
  wire [1:0]               mode;

  // Decode the operating mode from the control bits
  function [1:0] mode_of;
    input [7:0] c;
    begin
      if (!c[`T2BRC_B_RUN]) begin
        mode_of = `T2BRC_MODE_OFF;
      end else if (c[`T2BRC_B_RXSEL] | c[`T2BRC_B_TXSEL]) begin
        mode_of = `T2BRC_MODE_BAUD;
      end else if (c[`T2BRC_B_CAPSEL]) begin
        mode_of = `T2BRC_MODE_CAP;
      end else begin
        mode_of = `T2BRC_MODE_RLD;
      end
    end
  endfunction

  assign mode = mode_of(ctrl_ff);

  t2brc_edge u_trig (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_pin     (i_ext_trigger_pin),
    .o_fall    (trig_fall)
  );

  t2brc_edge u_cnt (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_pin     (i_ext_count_input),
    .o_fall    (cnt_fall)
  );

  // Prescaler length per mode; baud mode runs faster than a machine cycle
  always @* begin
    if (mode == `T2BRC_MODE_BAUD) begin
      pre_top = six_clk_ff ? `T2BRC_PRE_BR6 : `T2BRC_PRE_BR12;
    end else begin
      pre_top = six_clk_ff ? `T2BRC_PRE_MC6 : `T2BRC_PRE_MC12;
    end
  end

  // Count tick source; a stopped timer freezes the prescaler too
  always @* begin
    nxt_pre = pre_ff;
    tick    = 1'b0;
    if (mode != `T2BRC_MODE_OFF) begin
      if (ctrl_ff[`T2BRC_B_TCSEL]) begin
        tick = cnt_fall;
      end else if (pre_ff >= pre_top) begin
        nxt_pre = {`T2BRC_PRE_W{1'b0}};
        tick    = 1'b1;
      end else begin
        nxt_pre = pre_ff + 1'b1;
      end
    end
  end

  // Counter, capture, reload and flag logic
  always @* begin
    nxt_ctrl   = ctrl_ff;
    nxt_count  = count_ff;
    nxt_reload = reload_ff;
    roll       = tick && (count_ff == `T2BRC_MAX_CNT);
    ovf_set    = 1'b0;
    extf_set   = 1'b0;
    // Software writes first, so hardware sets below win over a clear
    if (i_wr) begin
      case (i_addr)
        `T2BRC_REG_CTRL:  nxt_ctrl = i_wdata;
        `T2BRC_REG_CNT_L: nxt_count[7:0] = i_wdata;
        `T2BRC_REG_CNT_H: nxt_count[15:8] = i_wdata;
        `T2BRC_REG_RLD_L: nxt_reload[7:0] = i_wdata;
        `T2BRC_REG_RLD_H: nxt_reload[15:8] = i_wdata;
        default: ;
      endcase
    end
    if (tick) begin
      nxt_count = count_ff + 1'b1;
    end
    case (mode)
      `T2BRC_MODE_RLD: begin
        if (roll) begin
          nxt_count = reload_ff;
          ovf_set   = 1'b1;
        end
        if (ctrl_ff[`T2BRC_B_EXTEN] && trig_fall) begin
          nxt_count = reload_ff;
          extf_set  = 1'b1;
        end
      end
      `T2BRC_MODE_CAP: begin
        if (roll) begin
          ovf_set = 1'b1;
        end
        if (ctrl_ff[`T2BRC_B_EXTEN] && trig_fall) begin
          nxt_reload = count_ff;
          extf_set   = 1'b1;
        end
      end
      `T2BRC_MODE_BAUD: begin
        if (roll) begin
          nxt_count = reload_ff;
        end
        // Pin edge only flags here; overflow flag untouched by rollover
        if (ctrl_ff[`T2BRC_B_EXTEN] && trig_fall) begin
          extf_set = 1'b1;
        end
      end
      default: ;
    endcase
    // Without the enable the trigger pin has no effect at all
    if (ovf_set) begin
      nxt_ctrl[`T2BRC_B_OVF] = 1'b1;
    end
    if (extf_set) begin
      nxt_ctrl[`T2BRC_B_EXTF] = 1'b1;
    end
  end

  // State registers
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl_ff    <= `T2BRC_CTRL_RST;
      count_ff   <= `T2BRC_CNT_RST;
      reload_ff  <= `T2BRC_CNT_RST;
      six_clk_ff <= 1'b0;
      pre_ff     <= {`T2BRC_PRE_W{1'b0}};
    end else begin
      ctrl_ff   <= nxt_ctrl;
      count_ff  <= nxt_count;
      reload_ff <= nxt_reload;
      pre_ff    <= nxt_pre;
      if (i_wr && i_addr == `T2BRC_REG_CFG) begin
        six_clk_ff <= i_wdata[`T2BRC_B_SIXCLK];
      end
    end
  end

  // Baud ticks to the serial port; the UART divides by 16 for the
  // final rate, giving fosc/(n*(65536-reload)) overall
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_tx_baud_tick <= 1'b0;
      o_rx_baud_tick <= 1'b0;
    end else begin
      o_tx_baud_tick <= ctrl_ff[`T2BRC_B_TXSEL] ?
                        (roll && mode == `T2BRC_MODE_BAUD) : i_timer1_ovf;
      o_rx_baud_tick <= ctrl_ff[`T2BRC_B_RXSEL] ?
                        (roll && mode == `T2BRC_MODE_BAUD) : i_timer1_ovf;
    end
  end

  // Flag level to the interrupt system, registered
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_irq_req <= 1'b0;
    end else begin
      o_irq_req <= nxt_ctrl[`T2BRC_B_OVF] | nxt_ctrl[`T2BRC_B_EXTF];
    end
  end

  // Read data one cycle after the strobe; unmapped reads zero
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        `T2BRC_REG_CTRL:  o_rdata <= ctrl_ff;
        `T2BRC_REG_CNT_L: o_rdata <= count_ff[7:0];
        `T2BRC_REG_CNT_H: o_rdata <= count_ff[15:8];
        `T2BRC_REG_RLD_L: o_rdata <= reload_ff[7:0];
        `T2BRC_REG_RLD_H: o_rdata <= reload_ff[15:8];
        `T2BRC_REG_CFG:   o_rdata <= {7'h00, six_clk_ff};
        default:          o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/t2brc_defines.vh
`ifndef T2BRC_DEFINES_VH
`define T2BRC_DEFINES_VH
// Register indices on the plain register port
`define T2BRC_ADDR_W     3
`define T2BRC_REG_CTRL   3'h0
`define T2BRC_REG_CNT_L  3'h1
`define T2BRC_REG_CNT_H  3'h2
`define T2BRC_REG_RLD_L  3'h3
`define T2BRC_REG_RLD_H  3'h4
`define T2BRC_REG_CFG    3'h5
// Control register bit positions
`define T2BRC_B_OVF      7
`define T2BRC_B_EXTF     6
`define T2BRC_B_RXSEL    5
`define T2BRC_B_TXSEL    4
`define T2BRC_B_EXTEN    3
`define T2BRC_B_RUN      2
`define T2BRC_B_TCSEL    1
`define T2BRC_B_CAPSEL   0
// Config register: bit 0 selects 6-clock mode
`define T2BRC_B_SIXCLK   0
// Reset values and counter maximum
`define T2BRC_CTRL_RST   8'h00
`define T2BRC_CNT_RST    16'h0000
`define T2BRC_MAX_CNT    16'hFFFF
// Prescale terminal counts, one less than the length in oscillator clocks
`define T2BRC_PRE_W      4
`define T2BRC_PRE_MC6    4'h5
`define T2BRC_PRE_MC12   4'hB
`define T2BRC_PRE_BR12   4'h1
`define T2BRC_PRE_BR6    4'h0
// Operating modes
`define T2BRC_MODE_OFF   2'h0
`define T2BRC_MODE_RLD   2'h1
`define T2BRC_MODE_CAP   2'h2
`define T2BRC_MODE_BAUD  2'h3
`endif

// >>> rtl/t2brc_edge.v
`timescale 1ns/1ps
`default_nettype none
// Falling-edge detector on a pin taken as synchronous to the clock
module t2brc_edge (
  input  wire i_clk,
  input  wire i_sys_rst,
  input  wire i_pin,
  output wire o_fall
);
  reg pin_d_ff;

  // Pin idles high, so the first sample does not fake an edge
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pin_d_ff <= 1'b1;
    end else begin
      pin_d_ff <= i_pin;
    end
  end

  assign o_fall = pin_d_ff & ~i_pin;
endmodule
`default_nettype wire

// >>> bench/t2brc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module t2brc_checker (
  input wire       i_clk,
  input wire       i_sys_rst,
  input wire [2:0] i_addr,
  input wire [7:0] i_wdata,
  input wire       i_wr,
  input wire       i_rd,
  input wire [7:0] o_rdata,
  input wire       i_ext_trigger_pin,
  input wire       i_timer1_ovf,
  input wire       o_tx_baud_tick,
  input wire       o_rx_baud_tick,
  input wire       o_irq_req
);
  // Shadow of the mode bits; quiet waits out the latency of a control write
  reg  [5:0] ctl_ff;
  reg  [2:0] wr_ff;
  wire       ctl_wr = i_wr && i_addr == 3'h0;
  wire       quiet  = !ctl_wr && wr_ff == 3'h0;
  wire       baud   = ctl_ff[2] && ctl_ff[5:4] != 2'h0;
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctl_ff <= 6'h00;
      wr_ff <= 3'h0;
    end else begin
      wr_ff <= {wr_ff[1:0], ctl_wr};
      if (ctl_wr) begin
        ctl_ff <= i_wdata[5:0];
      end
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  sequence pin_fall_s;
    $fell(i_ext_trigger_pin) && baud && ctl_ff[3] && quiet;
  endsequence
  tx_from_t1_a: assert property (
    !ctl_ff[4] && quiet |-> o_tx_baud_tick == $past(i_timer1_ovf)) else $error("tx src");
  rx_from_t1_a: assert property (
    !ctl_ff[5] && quiet |-> o_rx_baud_tick == $past(i_timer1_ovf)) else $error("rx src");
  both_same_a: assert property (
    ctl_ff[5:4] == 2'h3 && quiet |-> o_tx_baud_tick == o_rx_baud_tick) else $error("pair");
  stop_quiet_a: assert property (
    ctl_ff[4] && !ctl_ff[2] && quiet |-> !o_tx_baud_tick) else $error("tick stopped");
  baud_no_irq_a: assert property (
    baud && !ctl_ff[3] && quiet |-> !$rose(o_irq_req)) else $error("baud irq");
  ext_flag_a: assert property (
    pin_fall_s |-> ##[1:4] o_irq_req) else $error("ext flag");
  flag_hold_a: assert property (
    o_irq_req && !ctl_wr && !$past(ctl_wr) |=> o_irq_req) else $error("flag lost");
  mode_read_a: assert property (
    $past(i_rd && i_addr == 3'h0 && quiet) |-> o_rdata[5:0] == $past(ctl_ff))
    else $error("ctrl read");
  rdata_idle_a: assert property (
    !$past(i_rd) |-> o_rdata == 8'h00) else $error("rdata idle");
endmodule
bind t2brc_timer t2brc_checker i_t2brc_checker (.*);
`default_nettype wire

// >>> bench/t2brc_uart_model.sv
`timescale 1ns/1ps
`default_nettype none
module t2brc_uart_model #(
  parameter int GAP = 40
) (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_tx_tick,
  input  wire logic        i_rx_tick,
  output logic             o_timer1_ovf,
  output logic      [15:0] o_tx_cnt,
  output logic      [15:0] o_rx_cnt
);
  // Timer 1 stand-in pulses every GAP clocks; the serial side counts its rate ticks
  int div_ff;
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      div_ff <= 0;
      o_timer1_ovf <= 1'b0;
      o_tx_cnt <= 16'h0000;
      o_rx_cnt <= 16'h0000;
    end else begin
      div_ff <= (div_ff == GAP - 1) ? 0 : div_ff + 1;
      o_timer1_ovf <= div_ff == GAP - 1;
      o_tx_cnt <= o_tx_cnt + i_tx_tick;
      o_rx_cnt <= o_rx_cnt + i_rx_tick;
    end
  end
endmodule
`default_nettype wire

// >>> bench/test_timer2_baud_reload_capture.sv
`timescale 1ns/1ps
`default_nettype none
module test_timer2_baud_reload_capture;
  logic        i_clk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic  [2:0] i_addr = 3'h0;
  logic  [7:0] i_wdata = 8'h00;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic        i_ext_trigger_pin = 1'b1;
  logic        i_ext_count_input = 1'b1;
  wire logic   i_timer1_ovf, o_tx_baud_tick, o_rx_baud_tick, o_irq_req;
  wire logic   [7:0] o_rdata;
  wire logic   [15:0] tx_cnt, rx_cnt;
  int          errors = 0;
  int          total_checks = 0;
  int          cycles = 0;
  logic  [7:0] a, b, d;
  logic [15:0] t, r;
  t2brc_timer i_t2brc_timer (.*);
  t2brc_uart_model i_t2brc_uart_model (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_tx_tick(o_tx_baud_tick), .i_rx_tick(o_rx_baud_tick), .o_timer1_ovf(i_timer1_ovf),
    .o_tx_cnt(tx_cnt), .o_rx_cnt(rx_cnt));
  always #10 i_clk = ~i_clk;
  // Hang guard; the run needs about 1800 clocks
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      errors++;
      summarize();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bus cycles leave one idle clock so a strobe is never set and cleared together
  task automatic wr(input logic [2:0] ad, input logic [7:0] v);
    i_addr <= ad;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic rd(input logic [2:0] ad, output logic [7:0] v);
    i_addr <= ad;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    // Take the data mid-cycle while it stands, not on the edge that clears it
    @(negedge i_clk);
    v = o_rdata;
    @(posedge i_clk);
  endtask
  // Low count byte advance between two reads exactly 120 clocks apart
  task automatic span(output logic [7:0] v);
    rd(3'h1, a);
    repeat (118) @(posedge i_clk);
    rd(3'h1, b);
    v = b - a;
  endtask
  task automatic fall;
    i_ext_trigger_pin <= 1'b0;
    repeat (4) @(posedge i_clk);
    i_ext_trigger_pin <= 1'b1;
    repeat (4) @(posedge i_clk);
  endtask
  task automatic t_regs;
    wr(3'h6, 8'hFF);
    for (int i = 0; i < 8; i++) begin
      rd(i[2:0], a);
      chk(a, 8'h00);
    end
    $display("regs done");
  endtask
  task automatic t_timer;
    wr(3'h0, 8'h00);
    wr(3'h0, 8'h04);
    span(d);
    chk(d, 8'h0A);
    wr(3'h5, 8'h01);
    span(d);
    chk(d, 8'h14);
    wr(3'h0, 8'h00);
    span(d);
    chk(d, 8'h00);
    wr(3'h0, 8'h06);
    rd(3'h1, a);
    repeat (5) begin
      i_ext_count_input <= 1'b0;
      repeat (3) @(posedge i_clk);
      i_ext_count_input <= 1'b1;
      repeat (3) @(posedge i_clk);
    end
    rd(3'h1, b);
    d = b - a;
    chk(d, 8'h05);
    $display("timer done");
  endtask
  // Rate ticks in 320 clocks; each entry packs control, config, tx and rx counts
  task automatic t_baud;
    logic [31:0] tbl [3] = '{32'h14000A08, 32'h2400080A, 32'h34011414};
    wr(3'h0, 8'h00);
    wr(3'h1, 8'hF0);
    wr(3'h2, 8'hFF);
    wr(3'h3, 8'hF0);
    wr(3'h4, 8'hFF);
    foreach (tbl[i]) begin
      wr(3'h0, 8'h30);
      repeat (4) @(posedge i_clk);
      wr(3'h5, tbl[i][23:16]);
      wr(3'h0, tbl[i][31:24]);
      repeat (100) @(posedge i_clk);
      t = tx_cnt;
      r = rx_cnt;
      repeat (320) @(posedge i_clk);
      chk(tx_cnt - t, {8'h00, tbl[i][15:8]});
      chk(rx_cnt - r, {8'h00, tbl[i][7:0]});
    end
    $display("baud done");
  endtask
  task automatic t_ext;
    wr(3'h0, 8'h3C);
    repeat (4) @(posedge i_clk);
    fall();
    repeat (40) @(posedge i_clk);
    chk(o_irq_req, 1'b1);
    rd(3'h0, a);
    chk(a, 8'h7C);
    wr(3'h0, 8'h34);
    fall();
    chk(o_irq_req, 1'b0);
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h00);
    wr(3'h2, 8'h00);
    wr(3'h0, 8'h09);
    wr(3'h0, 8'h0D);
    fall();
    rd(3'h0, a);
    chk(a, 8'h4D);
    $display("ext done");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    t_regs();
    t_timer();
    t_baud();
    t_ext();
    summarize();
  end
endmodule
`default_nettype wire
